// [core/bcr_config_regs.sv]
// Configuration register bank of the step-down regulator, behind the serial byte engine.
//
// Functional notes
// - Control bit 7 turns spread-spectrum off at 0, on at 1; resets 0.
// - Control bit 6 selects ramp: 0 is 8 ms, 1 is 4 ms; resets 0.
// - Bits 5:4 code peak limit 700/800/900/1000 mA; reset 00.
// - Programmed limit applies only while the limit select pin is low.
// - Bit 3 is factory-set and read-only; writes leave it unchanged.
// - Enable combines bit 0 with pin; bit 1 picks OR at 0, AND at 1.
// - Voltage code sets output in 50 mV steps, 0x00 is 1.5 V.
// - External feedback variant ignores the voltage code for regulation.
// - Voltage code resets to 0x06, 0x24 or 0x46 by variant; read-write.
// - A written byte loads at the next data line rising edge after acknowledge or at the next data byte, whichever is first.
// - A stop condition leaves the register pointer unchanged.
`timescale 1ns/1ps
`default_nettype none

module bcr_config_regs #(
  parameter bcr_pkg::bcr_variant_t VARIANT      = bcr_pkg::BCR_VAR_LOW,
  parameter logic                  FACTORY_BIT  = 1'b0,
  parameter logic                  EXT_FEEDBACK = 1'b0
) (
  input  wire logic       core_clk,
  input  wire logic       rst,
  input  wire logic       ptr_wr,
  input  wire logic [7:0] ptr_data,
  input  wire logic       data_wr,
  input  wire logic [7:0] wr_data,
  input  wire logic       rd_next,
  input  wire logic       bus_stop,
  input  wire logic       sda_in,
  input  wire logic       en_pin,
  input  wire logic       current_cap_select_pin,
  output logic [7:0]      rd_data,
  output logic [7:0]      reg_pointer,
  output logic            spread_spectrum_on,
  output logic            ramp_time_select,
  output logic [1:0]      peak_limit_code,
  output logic            peak_limit_from_reg,
  output logic            regulator_enable,
  output logic [7:0]      output_voltage_code,
  output logic            vout_code_in_use
);

  localparam logic [7:0] CTRL_RST =
    bcr_pkg::BCR_CTRL_RST | (8'(FACTORY_BIT) << bcr_pkg::BCR_BIT_FACTORY);
  localparam logic [7:0] VOUT_RST = bcr_pkg::bcr_vout_reset(VARIANT);
  localparam logic [7:0] CTRL_WMASK = ~(8'h01 << bcr_pkg::BCR_BIT_FACTORY);

  // Pins: sda, enable, limit select. Three stages, filtered on stage two/three agreement.
  logic [2:0] sync1_r;
  logic [2:0] sync2_r;
  logic [2:0] sync3_r;
  logic [2:0] pin_r;
  logic [2:0] pin_nxt;

  logic [7:0] ctrl_r;
  logic [7:0] ctrl_nxt;
  logic [7:0] vout_r;
  logic [7:0] vout_nxt;
  logic [7:0] ptr_r;
  logic [7:0] ptr_nxt;
  logic [7:0] pend_data_r;
  logic [7:0] pend_ptr_r;
  logic       pend_r;
  logic       pend_nxt;
  logic [7:0] rd_data_r;
  logic [7:0] rd_sel;

  wire sda_f    = pin_r[0];
  wire en_f     = pin_r[1];
  wire current_cap_select_pin_f   = pin_r[2];
  wire sda_rise = pin_nxt[0] & ~sda_f;
  // A new data byte flushes an older pending byte so nothing is lost.
  wire commit    = pend_r & (sda_rise | data_wr);
  wire wr_ctrl   = commit & (pend_ptr_r == bcr_pkg::BCR_ADDR_CTRL);
  wire wr_vout   = commit & (pend_ptr_r == bcr_pkg::BCR_ADDR_VOUT);

  assign pin_nxt  = (sync2_r & sync3_r) | (pin_r & (sync2_r | sync3_r));
  assign ctrl_nxt = wr_ctrl ? ((pend_data_r & CTRL_WMASK) | (ctrl_r & ~CTRL_WMASK))
                            : ctrl_r;
  assign vout_nxt = wr_vout ? pend_data_r : vout_r;
  assign pend_nxt = data_wr | (pend_r & ~commit);
  // Pointer advances per data byte and per read byte; a stop leaves it alone.
  assign ptr_nxt  = ptr_wr ? ptr_data
                  : (data_wr | rd_next) ? ptr_r + 8'h01
                  : ptr_r;
  assign rd_sel   = (ptr_nxt == bcr_pkg::BCR_ADDR_CTRL) ? ctrl_nxt
                  : (ptr_nxt == bcr_pkg::BCR_ADDR_VOUT) ? vout_nxt
                  : 8'h00;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      // The data line idles high, so its stages start high and no false rise follows reset.
      sync1_r <= bcr_pkg::BCR_PIN_IDLE;
      sync2_r <= bcr_pkg::BCR_PIN_IDLE;
      sync3_r <= bcr_pkg::BCR_PIN_IDLE;
      pin_r   <= bcr_pkg::BCR_PIN_IDLE;
    end else begin
      sync1_r <= {current_cap_select_pin, en_pin, sda_in};
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
      pin_r   <= pin_nxt;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ctrl_r      <= CTRL_RST;
      vout_r      <= VOUT_RST;
      ptr_r       <= 8'h00;
      pend_r      <= 1'b0;
      pend_data_r <= 8'h00;
      pend_ptr_r  <= 8'h00;
      rd_data_r   <= 8'h00;
    end else begin
      ctrl_r    <= ctrl_nxt;
      vout_r    <= vout_nxt;
      ptr_r     <= ptr_nxt;
      pend_r    <= pend_nxt;
      rd_data_r <= rd_sel;
      if (data_wr) begin
        pend_data_r <= wr_data;
        pend_ptr_r  <= ptr_r;
      end
    end
  end

  assign rd_data             = rd_data_r;
  assign reg_pointer         = ptr_r;
  assign spread_spectrum_on  = ctrl_r[bcr_pkg::BCR_BIT_SPREAD];
  assign ramp_time_select    = ctrl_r[bcr_pkg::BCR_BIT_RAMP];
  assign peak_limit_code     = ctrl_r[bcr_pkg::BCR_LIM_HI:bcr_pkg::BCR_LIM_LO];
  assign peak_limit_from_reg = ~current_cap_select_pin_f;
  assign regulator_enable    = ctrl_r[bcr_pkg::BCR_BIT_EN_SEL]
                             ? (ctrl_r[bcr_pkg::BCR_BIT_SOFT_EN] & en_f)
                             : (ctrl_r[bcr_pkg::BCR_BIT_SOFT_EN] | en_f);
  assign output_voltage_code = vout_r;
  assign vout_code_in_use    = ~EXT_FEEDBACK;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  // Fixed and reset values.
  chk_factory_bit_fixed: assert property (ctrl_r[3] == FACTORY_BIT)
    else $error("factory bit changed");

  chk_ramp_reset: assert property (
    $past(rst) |-> ctrl_r[7:4] == 4'h0 && ctrl_r[2:0] == 3'h0)
    else $error("control reset value wrong");

  chk_vout_reset: assert property ($past(rst) |-> vout_r == VOUT_RST)
    else $error("voltage reset value wrong");

  // Write path: a pending byte lands only on a commit, and then in full except the factory bit.
  chk_commit_on_edge: assert property (
    pend_r && !sda_rise && !data_wr |=> $stable(ctrl_r) && $stable(vout_r))
    else $error("register changed without commit");

  chk_idle_no_change: assert property (
    !pend_r |=> $stable(ctrl_r) && $stable(vout_r))
    else $error("register changed with nothing pending");

  chk_ctrl_loaded: assert property (
    pend_r && sda_rise && pend_ptr_r == bcr_pkg::BCR_ADDR_CTRL
    |=> spread_spectrum_on == $past(pend_data_r[7])
    && ramp_time_select == $past(pend_data_r[6])
    && peak_limit_code == $past(pend_data_r[5:4]))
    else $error("control fields not loaded");

  chk_ctrl_low_loaded: assert property (
    pend_r && sda_rise && pend_ptr_r == bcr_pkg::BCR_ADDR_CTRL
    |=> ctrl_r[2:0] == $past(pend_data_r[2:0]))
    else $error("enable fields not loaded");

  chk_vout_loaded: assert property (
    pend_r && sda_rise && pend_ptr_r == bcr_pkg::BCR_ADDR_VOUT
    |=> bcr_pkg::bcr_vout_mv(output_voltage_code) == bcr_pkg::bcr_vout_mv($past(pend_data_r)))
    else $error("voltage code not loaded");

  chk_ctrl_hold: assert property (
    !wr_ctrl |=> $stable({spread_spectrum_on, ramp_time_select, peak_limit_code}))
    else $error("control outputs moved without a write");

  // Enable combination, limit selection and feedback mode.
  chk_enable_combine: assert property (
    regulator_enable == (ctrl_r[1] ? (ctrl_r[0] && en_f) : (ctrl_r[0] || en_f)))
    else $error("enable combine wrong");

  chk_enable_or_mode: assert property (
    !ctrl_r[1] && (ctrl_r[0] || en_f) |-> regulator_enable)
    else $error("enable missing in or mode");

  chk_enable_and_mode: assert property (
    ctrl_r[1] && !(ctrl_r[0] && en_f) |-> !regulator_enable)
    else $error("enable present in and mode");

  chk_limit_gate: assert property ($rose(current_cap_select_pin_f) |-> !peak_limit_from_reg)
    else $error("register limit used while pin high");

  chk_limit_pin_low: assert property (!current_cap_select_pin_f |-> peak_limit_from_reg)
    else $error("register limit ignored while pin low");

  chk_feedback_mode: assert property (vout_code_in_use == !EXT_FEEDBACK)
    else $error("voltage code use flag wrong");

  // Pointer and read path.
  chk_ptr_on_stop: assert property (
    bus_stop && !ptr_wr && !data_wr && !rd_next |=> reg_pointer == $past(reg_pointer))
    else $error("pointer moved on stop");

  chk_read_data: assert property (
    rd_next && !ptr_wr ##1 !ptr_wr && !data_wr && !rd_next && !commit
    |=> reg_pointer != bcr_pkg::BCR_ADDR_VOUT || rd_data == vout_r)
    else $error("read data mismatch");

  // Main scenarios.
  cov_ctrl_write: cover property (pend_r && sda_rise && pend_ptr_r == 8'h00);
  cov_vout_write: cover property (pend_r && sda_rise && pend_ptr_r == 8'h01);
  cov_and_enable: cover property (ctrl_r[1] && en_f && ctrl_r[0] && regulator_enable);
  cov_or_enable: cover property (!ctrl_r[1] && en_f && !ctrl_r[0] && regulator_enable);
  cov_seq_read: cover property (rd_next && !ptr_wr);

endmodule

`default_nettype wire

// [core/bcr_pkg.sv]
// Package with register map, field layout and reset constants of the regulator config bank.
package bcr_pkg;

  localparam logic [7:0] BCR_ADDR_CTRL = 8'h00;
  localparam logic [7:0] BCR_ADDR_VOUT = 8'h01;

  // Field positions in the regulator control register.
  localparam int BCR_BIT_SPREAD   = 7;
  localparam int BCR_BIT_RAMP     = 6;
  localparam int BCR_LIM_HI       = 5;
  localparam int BCR_LIM_LO       = 4;
  localparam int BCR_BIT_FACTORY  = 3;
  localparam int BCR_BIT_RESV     = 2;
  localparam int BCR_BIT_EN_SEL   = 1;
  localparam int BCR_BIT_SOFT_EN  = 0;

  // Reset value of the control register, factory bit excluded.
  localparam logic [7:0] BCR_CTRL_RST = 8'h00;

  // Output voltage code reset values, one per factory variant.
  localparam logic [7:0] BCR_VOUT_RST_V0 = 8'h06;
  localparam logic [7:0] BCR_VOUT_RST_V1 = 8'h24;
  localparam logic [7:0] BCR_VOUT_RST_V2 = 8'h46;
  localparam logic [7:0] BCR_VOUT_MAX    = 8'h78;

  // Output voltage scale in millivolts.
  localparam int BCR_VOUT_BASE_MV = 1500;
  localparam int BCR_VOUT_STEP_MV = 50;

  // Ramp durations in milliseconds for the two ramp selections.
  localparam int BCR_RAMP_SLOW_MS = 8;
  localparam int BCR_RAMP_FAST_MS = 4;

  // Peak current limit in milliamps for each limit code.
  localparam int BCR_LIM_BASE_MA = 700;
  localparam int BCR_LIM_STEP_MA = 100;

  // Depth of the pin synchronisers.
  localparam int BCR_SYNC_STAGES = 3;

  // Pin stage levels during reset: data line idles high, enable and limit select low.
  localparam logic [2:0] BCR_PIN_IDLE = 3'h1;

  typedef enum logic [1:0] {
    BCR_VAR_LOW,
    BCR_VAR_MID,
    BCR_VAR_HIGH
  } bcr_variant_t;

  function automatic logic [7:0] bcr_vout_reset(input bcr_variant_t v);
    case (v)
      BCR_VAR_MID:  return BCR_VOUT_RST_V1;
      BCR_VAR_HIGH: return BCR_VOUT_RST_V2;
      default:      return BCR_VOUT_RST_V0;
    endcase
  endfunction

  function automatic int bcr_vout_mv(input logic [7:0] code);
    return BCR_VOUT_BASE_MV + BCR_VOUT_STEP_MV * int'(code);
  endfunction

endpackage

// [dv/bcr_bus_master.sv]
// Behavioural serial-engine master that feeds byte events to the config bank.
`timescale 1ns/1ps
`default_nettype none
module bcr_bus_master (
  input  wire logic       core_clk,
  input  wire logic [7:0] rd_data,
  output logic            ptr_wr,
  output logic [7:0]      ptr_data,
  output logic            data_wr,
  output logic [7:0]      wr_data,
  output logic            bus_stop,
  output logic            sda_in
);
  initial {ptr_wr, ptr_data, data_wr, wr_data, bus_stop, sda_in} = 20'h0_0001;
  task automatic step();
    @(posedge core_clk);
    #1;
  endtask
  // Sends a pointer and one byte, leaving the data line low as the acknowledge.
  task automatic put(input logic [7:0] p, input logic [7:0] d);
    step();
    ptr_wr   = 1'b1;
    ptr_data = p;
    step();
    ptr_wr  = 1'b0;
    data_wr = 1'b1;
    wr_data = (p == 8'h00) ? (d & 8'hFB) : d;
    step();
    data_wr = 1'b0;
    sda_in  = 1'b0;
  endtask
  task automatic rise();
    repeat (5) step();
    sda_in = 1'b1;
    repeat (8) step();
  endtask
  task automatic get(input logic [7:0] p, output logic [7:0] v);
    step();
    ptr_wr   = 1'b1;
    ptr_data = p;
    step();
    ptr_wr = 1'b0;
    repeat (2) step();
    v = rd_data;
  endtask
  task automatic stop();
    step();
    bus_stop = 1'b1;
    step();
    bus_stop = 1'b0;
    repeat (2) step();
  endtask
endmodule
`default_nettype wire

// [dv/tb.sv]
// Self-checking bench for the regulator configuration register bank.
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic       core_clk, rst, ptr_wr, data_wr, rd_next, bus_stop, sda_in, en_pin, cap_pin;
  logic [7:0] ptr_data, wr_data, rd_data, reg_pointer, vout, v, vout_ext;
  logic       spread, ramp, from_reg, reg_en, in_use, in_use_ext;
  int         pend_q[$];
  logic [1:0] lim;
  int         n_fail = 0, checks = 0, seed = 62, d, ctrl_m, vout_m;
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  bcr_config_regs #(.VARIANT(bcr_pkg::BCR_VAR_MID), .FACTORY_BIT(1'b1)) DUT (
    .core_clk(core_clk), .rst(rst), .ptr_wr(ptr_wr), .ptr_data(ptr_data),
    .data_wr(data_wr), .wr_data(wr_data), .rd_next(rd_next), .bus_stop(bus_stop),
    .sda_in(sda_in), .en_pin(en_pin), .current_cap_select_pin(cap_pin),
    .rd_data(rd_data), .reg_pointer(reg_pointer), .spread_spectrum_on(spread),
    .ramp_time_select(ramp), .peak_limit_code(lim), .peak_limit_from_reg(from_reg),
    .regulator_enable(reg_en), .output_voltage_code(vout), .vout_code_in_use(in_use));
  bcr_config_regs #(.EXT_FEEDBACK(1'b1)) DUT_EXT (
    .core_clk(core_clk), .rst(rst), .ptr_wr(ptr_wr), .ptr_data(ptr_data),
    .data_wr(data_wr), .wr_data(wr_data), .rd_next(rd_next), .bus_stop(bus_stop),
    .sda_in(sda_in), .en_pin(en_pin), .current_cap_select_pin(cap_pin),
    .rd_data(), .reg_pointer(), .spread_spectrum_on(), .ramp_time_select(),
    .peak_limit_code(), .peak_limit_from_reg(), .regulator_enable(),
    .output_voltage_code(vout_ext), .vout_code_in_use(in_use_ext));
  bcr_bus_master m (
    .core_clk(core_clk), .rd_data(rd_data), .ptr_wr(ptr_wr), .ptr_data(ptr_data),
    .data_wr(data_wr), .wr_data(wr_data), .bus_stop(bus_stop), .sda_in(sda_in));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wrap_up();
    $display("checks=%0d n_fail=%0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic cmp_all();
    chk(8'({spread, ramp, lim}), 8'(ctrl_m >> 4));
    chk(8'(reg_en), 8'(ctrl_m[1] ? ctrl_m[0] & en_pin : ctrl_m[0] | en_pin));
    chk(vout, 8'(vout_m));
    m.get(8'h00, v);
    chk(v, 8'(ctrl_m));
    m.get(8'h01, v);
    chk(v, 8'(vout_m));
  endtask
  initial begin
    {rst, rd_next, en_pin, cap_pin} = 4'h8;
    ctrl_m = 8'h08;
    vout_m = bcr_pkg::BCR_VOUT_RST_V1;
    repeat (2) @(posedge core_clk);
    #1 rst = 1'b0;
    cmp_all();
    chk(8'(in_use), 8'h01);
    chk(8'(from_reg), 8'h01);
    chk(8'(in_use_ext), 8'h00);
    chk(vout_ext, bcr_pkg::BCR_VOUT_RST_V0);
    $display("test reset done");
    for (int i = 0; i < 8; i++) begin
      d = $random(seed);
      en_pin = d[8];
      m.put(8'h00, 8'(d));
      chk(8'({spread, ramp, lim}), 8'(ctrl_m >> 4));
      m.rise();
      // Bit 2 is cleared by the master and bit 3 keeps its factory value.
      ctrl_m = (d & 8'hF3) | 8'h08;
      d = $unsigned($random(seed)) % 121;
      pend_q.push_back(d);
      m.put(8'h01, 8'(d));
      chk(vout, 8'(vout_m));
      m.rise();
      vout_m = pend_q.pop_front();
      cmp_all();
    end
    $display("test random writes done");
    m.stop();
    chk(reg_pointer, 8'h01);
    m.get(8'h00, v);
    @(posedge core_clk);
    #1 rd_next = 1'b1;
    @(posedge core_clk);
    #1 rd_next = 1'b0;
    @(posedge core_clk);
    #1 chk(rd_data, 8'(vout_m));
    chk(reg_pointer, 8'h01);
    m.get(8'h07, v);
    chk(v, 8'h00);
    cap_pin = 1'b1;
    repeat (6) @(posedge core_clk);
    chk(8'(from_reg), 8'h00);
    $display("test stop, unmapped, pin done");
    wrap_up();
  end
  initial begin
    repeat (20000) @(posedge core_clk);
    n_fail++;
    wrap_up();
  end
endmodule
`default_nettype wire
